// ===== logic/ppp_defs.svh
// How it works
// - Every strobe pulse lasts at least 250 ns.
// - Host releases data bus while output enable low.
// - Entry: reset low, six toggles, pattern zero.
// - Pattern pins steady 100 ns after high voltage.
// - Wait 50 us before first command.
// - Erase before reprogramming flash or EEPROM.
// - Erase write pulse; wait ready before next.
// - Command load: action 10, low select 0.
// - Address load: action 00 with byte select.
// - Data load: action 01, low select picks byte.
// - Page latch pulse stores loaded data word.
// - Write pulse with selects 00 programs page.
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

`define PPP_ADDR_CTRL 4'h0
`define PPP_ADDR_STATUS 4'h4

`define PPP_CTRL_OP_LSB 0
`define PPP_CTRL_BS_LSB 4
`define PPP_CTRL_DATA_LSB 8
`define PPP_CTRL_ACT_LSB 16

`define PPP_OP_NOP 3'h0
`define PPP_OP_LOAD 3'h1
`define PPP_OP_WRITE 3'h2
`define PPP_OP_READ 3'h3
`define PPP_OP_LATCH 3'h4
`define PPP_OP_ENTER 3'h5
`define PPP_OP_EXIT 3'h6

`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3

`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03

`define PPP_RESP_OKAY 2'h0
`define PPP_RESP_SLVERR 2'h2

`define PPP_MCLK_MHZ 25
`define PPP_PULSE_NS 250
`define PPP_SETTLE_NS 100
`define PPP_START_US 50
`define PPP_ENTRY_TOGGLES 6
`define PPP_PULSE_CYC ((`PPP_PULSE_NS * `PPP_MCLK_MHZ + 999) / 1000)
`define PPP_SETTLE_CYC ((`PPP_SETTLE_NS * `PPP_MCLK_MHZ + 999) / 1000)
`define PPP_START_CYC (`PPP_START_US * `PPP_MCLK_MHZ)

`endif

// ===== logic/ppp_host.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ppp_defs.svh"
module ppp_host (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [3:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [3:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_load_pulse_pin,
    output logic o_pulse_action_sel_0,
    output logic o_pulse_action_sel_1,
    output logic o_byte_select_lo,
    output logic o_byte_select_hi,
    output logic o_page_latch_strobe,
    output logic o_wr_b,
    output logic o_oe_b,
    output logic [7:0] o_data_out,
    output logic o_data_oe,
    input wire logic [7:0] i_data_in,
    input wire logic i_ready_busy_out,
    output logic o_target_rst_b,
    output logic o_hv_enable
);
    localparam logic [11:0] PULSE_LAST = 12'(`PPP_PULSE_CYC - 1);
    localparam logic [11:0] SETTLE_LAST = 12'(`PPP_SETTLE_CYC - 1);
    localparam logic [11:0] START_LAST = 12'(`PPP_START_CYC - 1);
    localparam logic [3:0] TOGGLE_LAST = 4'(2 * `PPP_ENTRY_TOGGLES - 1);

    logic [8:0] sync_q;
    logic rdy_s;
    logic [7:0] din_s;

    // Ready and read-back data come from pins in another timing domain
    ppp_sync #(.WIDTH(9)) u_sync (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_async({i_ready_busy_out, i_data_in}),
        .o_sync(sync_q)
    );
    assign rdy_s = sync_q[8];
    assign din_s = sync_q[7:0];

    ppp_pkg::ppp_state_t state, next_state;
    logic [11:0] cnt, next_cnt;
    logic [3:0] tog, next_tog;
    logic [2:0] op, next_op;
    logic [7:0] last_cmd, next_last_cmd;
    logic [7:0] rd_data, next_rd_data;
    logic in_mode, next_in_mode;
    logic erased, next_erased;
    logic err_unerased, next_err_unerased;
    logic err_refused, next_err_refused;
    logic next_load, next_act0, next_act1, next_bs_lo, next_bs_hi, next_latch;
    logic next_wr_b, next_oe_b, next_data_oe, next_rst_b, next_hv;
    logic [7:0] next_data_out;
    logic next_awready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    logic start;
    logic [2:0] c_op;
    logic [1:0] c_bs;
    logic [1:0] c_act;
    logic [7:0] c_data;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;

    assign c_op = i_s_axi_wdata[`PPP_CTRL_OP_LSB +: 3];
    assign c_bs = i_s_axi_wdata[`PPP_CTRL_BS_LSB +: 2];
    assign c_data = i_s_axi_wdata[`PPP_CTRL_DATA_LSB +: 8];
    assign c_act = i_s_axi_wdata[`PPP_CTRL_ACT_LSB +: 2];
    // Only a full-word write to the control register starts a step
    assign start = o_s_axi_awready && (i_s_axi_awaddr == `PPP_ADDR_CTRL)
        && (i_s_axi_wstrb == 4'hF);
    assign status_word = {16'h0000, rd_data, 2'b00, err_refused, err_unerased,
        erased, rdy_s, in_mode, state != ppp_pkg::ST_IDLE};
    assign ctrl_word = {14'h0000, o_pulse_action_sel_1, o_pulse_action_sel_0, o_data_out,
        2'b00, o_byte_select_hi, o_byte_select_lo, 1'b0, op};

    always_comb begin
        next_awready = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready
            && !o_s_axi_bvalid;
        next_bvalid = o_s_axi_bvalid && !i_s_axi_bready;
        next_bresp = o_s_axi_bresp;
        if (o_s_axi_awready) begin
            next_bvalid = 1'b1;
            next_bresp = start ? `PPP_RESP_OKAY : `PPP_RESP_SLVERR;
        end
        next_arready = i_s_axi_arvalid && !o_s_axi_arready && !o_s_axi_rvalid;
        next_rvalid = o_s_axi_rvalid && !i_s_axi_rready;
        next_rdata = o_s_axi_rdata;
        next_rresp = o_s_axi_rresp;
        if (o_s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `PPP_RESP_OKAY;
            if (i_s_axi_araddr == `PPP_ADDR_STATUS) begin
                next_rdata = status_word;
            end else if (i_s_axi_araddr == `PPP_ADDR_CTRL) begin
                next_rdata = ctrl_word;
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = `PPP_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= 2'h0;
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= 2'h0;
        end else begin
            o_s_axi_awready <= next_awready;
            o_s_axi_wready <= next_awready;
            o_s_axi_bvalid <= next_bvalid;
            o_s_axi_bresp <= next_bresp;
            o_s_axi_arready <= next_arready;
            o_s_axi_rvalid <= next_rvalid;
            o_s_axi_rdata <= next_rdata;
            o_s_axi_rresp <= next_rresp;
        end
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt + 12'h001;
        next_tog = tog;
        next_op = op;
        next_last_cmd = last_cmd;
        next_rd_data = rd_data;
        next_in_mode = in_mode;
        next_erased = erased;
        next_err_unerased = err_unerased;
        next_err_refused = err_refused;
        next_load = o_load_pulse_pin;
        next_act0 = o_pulse_action_sel_0;
        next_act1 = o_pulse_action_sel_1;
        next_bs_lo = o_byte_select_lo;
        next_bs_hi = o_byte_select_hi;
        next_latch = o_page_latch_strobe;
        next_wr_b = o_wr_b;
        next_oe_b = o_oe_b;
        next_data_out = o_data_out;
        next_data_oe = o_data_oe;
        next_rst_b = o_target_rst_b;
        next_hv = o_hv_enable;
        case (state)
            ppp_pkg::ST_IDLE: begin
                next_cnt = 12'h000;
                next_tog = 4'h0;
                if (start) begin
                    next_err_unerased = 1'b0;
                    next_err_refused = 1'b0;
                    if (c_op == `PPP_OP_ENTER) begin
                        if (in_mode) begin
                            next_err_refused = 1'b1;
                        end else begin
                            // Reset low and entry pattern all zero
                            next_rst_b = 1'b0;
                            next_hv = 1'b0;
                            next_data_oe = 1'b0;
                            next_load = 1'b0;
                            next_act0 = 1'b0;
                            next_act1 = 1'b0;
                            next_bs_lo = 1'b0;
                            next_latch = 1'b0;
                            next_state = ppp_pkg::ST_TOGGLE;
                        end
                    end else if (c_op == `PPP_OP_EXIT) begin
                        next_hv = 1'b0;
                        next_rst_b = 1'b1;
                        next_in_mode = 1'b0;
                        next_erased = 1'b0;
                    end else if (c_op == `PPP_OP_NOP) begin
                        next_op = c_op;
                    end else if (!in_mode || c_op > `PPP_OP_LATCH) begin
                        next_err_refused = 1'b1;
                    end else if (c_op == `PPP_OP_LOAD && c_act == `PPP_ACT_CMD && !erased
                        && (c_data == `PPP_CMD_WR_FLASH || c_data == `PPP_CMD_WR_EEPROM)) begin
                        next_err_unerased = 1'b1;
                    end else begin
                        next_op = c_op;
                        // Pins other than a load leave the action at idle
                        next_act0 = (c_op == `PPP_OP_LOAD) ? c_act[0] : 1'b1;
                        next_act1 = (c_op == `PPP_OP_LOAD) ? c_act[1] : 1'b1;
                        next_bs_hi = c_bs[1];
                        next_bs_lo = (c_op == `PPP_OP_LOAD && c_act == `PPP_ACT_CMD)
                            ? 1'b0 : c_bs[0];
                        next_data_out = c_data;
                        next_data_oe = (c_op != `PPP_OP_READ);
                        if (c_op == `PPP_OP_LOAD && c_act == `PPP_ACT_CMD) begin
                            next_last_cmd = c_data;
                        end
                        next_state = ppp_pkg::ST_SETUP;
                    end
                end
            end
            ppp_pkg::ST_SETUP: begin
                if (cnt == SETTLE_LAST) begin
                    next_cnt = 12'h000;
                    next_state = ppp_pkg::ST_STROBE;
                    next_load = (op == `PPP_OP_LOAD);
                    next_wr_b = (op != `PPP_OP_WRITE);
                    next_oe_b = (op != `PPP_OP_READ);
                    next_latch = (op == `PPP_OP_LATCH);
                end
            end
            ppp_pkg::ST_STROBE: begin
                if (cnt == PULSE_LAST) begin
                    next_cnt = 12'h000;
                    next_state = ppp_pkg::ST_HOLD;
                    next_load = 1'b0;
                    next_wr_b = 1'b1;
                    next_oe_b = 1'b1;
                    next_latch = 1'b0;
                    if (op == `PPP_OP_READ) begin
                        next_rd_data = din_s;
                    end
                end
            end
            ppp_pkg::ST_HOLD: begin
                // Bus stays released after a read until the next load, write or latch step starts
                if (cnt == SETTLE_LAST) begin
                    next_cnt = 12'h000;
                    next_state = (op == `PPP_OP_WRITE) ? ppp_pkg::ST_RDY : ppp_pkg::ST_IDLE;
                end
            end
            ppp_pkg::ST_RDY: begin
                // Hold off every further step until the device is ready
                if (rdy_s) begin
                    next_state = ppp_pkg::ST_IDLE;
                    if (last_cmd == `PPP_CMD_ERASE) begin
                        next_erased = 1'b1;
                    end
                end
            end
            ppp_pkg::ST_TOGGLE: begin
                if (cnt == PULSE_LAST) begin
                    next_cnt = 12'h000;
                    next_load = !o_load_pulse_pin;
                    next_tog = tog + 4'h1;
                    if (tog == TOGGLE_LAST) begin
                        next_state = ppp_pkg::ST_PATTERN;
                    end
                end
            end
            ppp_pkg::ST_PATTERN: begin
                if (cnt == SETTLE_LAST) begin
                    next_cnt = 12'h000;
                    // Reset pin is taken over by the high-voltage driver
                    next_rst_b = 1'b1;
                    next_hv = 1'b1;
                    next_state = ppp_pkg::ST_HV_HOLD;
                end
            end
            ppp_pkg::ST_HV_HOLD: begin
                if (cnt == SETTLE_LAST) begin
                    next_cnt = 12'h000;
                    next_state = ppp_pkg::ST_SETTLE;
                end
            end
            ppp_pkg::ST_SETTLE: begin
                if (cnt == START_LAST) begin
                    next_cnt = 12'h000;
                    next_in_mode = 1'b1;
                    next_state = ppp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = ppp_pkg::ST_IDLE;
            end
        endcase
        if (start && state != ppp_pkg::ST_IDLE) begin
            next_err_refused = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ppp_pkg::ST_IDLE;
            cnt <= 12'h000;
            tog <= 4'h0;
            op <= 3'h0;
            last_cmd <= 8'h00;
            rd_data <= 8'h00;
            in_mode <= 1'b0;
            erased <= 1'b0;
            err_unerased <= 1'b0;
            err_refused <= 1'b0;
            o_load_pulse_pin <= 1'b0;
            o_pulse_action_sel_0 <= 1'b0;
            o_pulse_action_sel_1 <= 1'b0;
            o_byte_select_lo <= 1'b0;
            o_byte_select_hi <= 1'b0;
            o_page_latch_strobe <= 1'b0;
            o_wr_b <= 1'b1;
            o_oe_b <= 1'b1;
            o_data_out <= 8'h00;
            o_data_oe <= 1'b0;
            o_target_rst_b <= 1'b0;
            o_hv_enable <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            tog <= next_tog;
            op <= next_op;
            last_cmd <= next_last_cmd;
            rd_data <= next_rd_data;
            in_mode <= next_in_mode;
            erased <= next_erased;
            err_unerased <= next_err_unerased;
            err_refused <= next_err_refused;
            o_load_pulse_pin <= next_load;
            o_pulse_action_sel_0 <= next_act0;
            o_pulse_action_sel_1 <= next_act1;
            o_byte_select_lo <= next_bs_lo;
            o_byte_select_hi <= next_bs_hi;
            o_page_latch_strobe <= next_latch;
            o_wr_b <= next_wr_b;
            o_oe_b <= next_oe_b;
            o_data_out <= next_data_out;
            o_data_oe <= next_data_oe;
            o_target_rst_b <= next_rst_b;
            o_hv_enable <= next_hv;
        end
    end

    // Helper counters read only by the checks below
    logic [3:0] ast_rises;
    logic [11:0] ast_since_hv;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ast_rises <= 4'h0;
            ast_since_hv <= 12'h000;
        end else begin
            if (o_hv_enable) begin
                ast_since_hv <= (ast_since_hv == 12'hFFF) ? ast_since_hv : ast_since_hv + 12'h001;
            end else begin
                ast_since_hv <= 12'h000;
            end
            if (state == ppp_pkg::ST_IDLE && !o_hv_enable) begin
                ast_rises <= 4'h0;
            end else if (!o_load_pulse_pin && next_load && !o_target_rst_b) begin
                ast_rises <= ast_rises + 4'h1;
            end
        end
    end

    AST_LOAD_WIDTH:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_load_pulse_pin) |-> o_load_pulse_pin [*7])
        else $error("Load pulse shorter than minimum");
    AST_WR_WIDTH:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $fell(o_wr_b) |-> !o_wr_b [*7] ##1 o_wr_b)
        else $error("Write pulse width wrong");
    AST_BUS_RELEASE:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            !o_oe_b |-> !o_data_oe && $past(!o_data_oe))
        else $error("Data bus driven while device output enabled");
    AST_CMD_LOW_SELECT:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_load_pulse_pin) && o_pulse_action_sel_1 && !o_pulse_action_sel_0
            |-> !o_byte_select_lo && o_data_oe)
        else $error("Command load with low byte select set");
    AST_ENTRY_TOGGLES:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_hv_enable) |-> ast_rises >= 4'(`PPP_ENTRY_TOGGLES)
            && $past(!o_pulse_action_sel_0 && !o_pulse_action_sel_1, 3))
        else $error("Entry without toggles or zero pattern");
    AST_PATTERN_STEADY:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_hv_enable) |-> (!o_page_latch_strobe && !o_pulse_action_sel_1
            && !o_pulse_action_sel_0 && !o_byte_select_lo) [*3])
        else $error("Entry pattern moved after high voltage");
    AST_FIRST_CMD_GAP:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_load_pulse_pin) && o_hv_enable |-> ast_since_hv >= 12'(`PPP_START_CYC))
        else $error("Command sent too soon after entry");
    AST_ERASE_FIRST:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_load_pulse_pin) && o_pulse_action_sel_1 && !o_pulse_action_sel_0
            && (o_data_out == `PPP_CMD_WR_FLASH || o_data_out == `PPP_CMD_WR_EEPROM)
            |-> erased)
        else $error("Write command loaded without erase");
    AST_WAIT_READY:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            state == ppp_pkg::ST_RDY && !rdy_s |=> !o_load_pulse_pin && o_wr_b
            && state == ppp_pkg::ST_RDY)
        else $error("Step issued while device busy");
    AST_LATCH_WIDTH:
        assert property (@(posedge i_mclk) disable iff (!i_rst_b)
            $rose(o_page_latch_strobe) |-> o_page_latch_strobe [*7] ##1 !o_page_latch_strobe)
        else $error("Page latch pulse width wrong");
endmodule // ppp_host
`default_nettype wire

// ===== logic/ppp_pkg.sv
package ppp_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_RDY,
        ST_TOGGLE,
        ST_PATTERN,
        ST_HV_HOLD,
        ST_SETTLE
    } ppp_state_t;
endpackage

// ===== logic/ppp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule // ppp_sync
`default_nettype wire

// ===== verif/parallel_programming_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module parallel_programming_port_tb_top;
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [3:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdat;
    logic [1:0] rsp, br, rr;
    logic awr, arr, bv, rv, ld, a0, a1, bl, bh, pg, wrb, oeb, doe, trst, hv, rdy;
    logic [7:0] dout, drv, bus, d, last = 0, fx [4];
    logic [15:0] w;
    int err_count = 0, cmp_count = 0, cyc = 0, lw = 0, lp = 0, np = 0;
    realtime t_hv = 0;
    initial forever #20 clk = ~clk;
    // Released bus keeps changing so a stale value never looks valid
    assign bus = doe ? dout : (!oeb ? drv : ~last);
    always @(posedge clk) last <= rst_b ? bus : 8'h00;
    ppp_host dut (.i_mclk(clk), .i_rst_b(rst_b), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
        .o_s_axi_wready(), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .o_s_axi_bresp(br),
        .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat),
        .o_s_axi_rresp(rr), .o_load_pulse_pin(ld), .o_pulse_action_sel_0(a0),
        .o_pulse_action_sel_1(a1), .o_byte_select_lo(bl), .o_byte_select_hi(bh),
        .o_page_latch_strobe(pg), .o_wr_b(wrb), .o_oe_b(oeb), .o_data_out(dout),
        .o_data_oe(doe), .i_data_in(bus), .i_ready_busy_out(rdy),
        .o_target_rst_b(trst), .o_hv_enable(hv));
    ppp_dev_model m (.i_load(ld), .i_act({a1, a0}), .i_bs({bh, bl}), .i_wr_b(wrb), .i_latch(pg),
        .i_bus(bus), .o_drv(drv), .o_ready_busy_out(rdy));
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] dw);
        @(posedge clk);
        awv <= 1; wv <= 1; awa <= a; wd <= dw; bre <= 1;
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 0; wv <= 0;
        do @(posedge clk); while (bv !== 1'b1);
        bre <= 0; rsp = br;
    endtask
    task automatic axr(input logic [3:0] a);
        @(posedge clk);
        arv <= 1; ara <= a; rre <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1);
        rre <= 0; rd = rdat; rsp = rr;
    endtask
    task automatic step(input logic [2:0] op, input logic [1:0] act, bs, input logic [7:0] v);
        axw(4'h0, {14'h0, act, v, 2'h0, bs, 1'b0, op});
        do axr(4'h4); while (rd[0] !== 1'b0);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ld === 1'b1) lw <= lw + 1;
        else if (lw != 0) begin
            chk("pulse_len", lw, 7);
            lw <= 0;
        end
        if (pg === 1'b1) lp <= lp + 1;
        else if (lp != 0) begin
            chk("latch_len", lp, 7);
            lp <= 0;
        end
        if (cyc == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    always @(posedge ld) begin
        if (hv && np == 6) chk("start_wait", ($realtime - t_hv) >= 50000, 1);
        np++;
    end
    always @(posedge hv) begin
        t_hv = $realtime;
        chk("entry_cnt", np, 6);
        chk("entry_pat", {a1, a0, bl, pg}, 0);
        #100;
        chk("entry_hold", {a1, a0, bl, pg}, 0);
    end
    initial begin
        void'($urandom(75));
        fx = '{8'h3C, 8'hFF, 8'hF3, 8'h5A};
        repeat (20) @(posedge clk);
        rst_b <= 1;
        chk("rst_pins", {trst, hv, wrb, oeb}, 4'h3);
        axr(4'h8);
        chk("bad_rd", rsp, 2'h2);
        axw(4'hC, 0);
        chk("bad_wr", rsp, 2'h2);
        step(1, 2, 0, 8'h80);
        chk("refused", rd[5], 1);
        step(5, 0, 0, 0);
        chk("in_mode", {rd[1], hv, trst}, 3'h7);
        for (int b = 0; b < 3; b++) begin
            d = $urandom;
            step(1, 0, b, d);
            chk("addr", m.adr[b], d);
        end
        step(1, 3, 0, 8'h55);
        chk("idle", m.cmd, 8'h00);
        step(1, 2, 0, 8'h10);
        chk("unerased", {rd[4], m.cmd}, 9'h100);
        step(1, 2, 1, 8'h80);
        chk("cmd_sel", m.cmd_bs, 0);
        step(2, 3, 0, 0);
        chk("erased", {rd[3], rdy}, 2'h3);
        chk("ee_erase", m.ee[0], 8'hFF);
        step(1, 2, 0, 8'h10);
        chk("wr_cmd", {rd[4], m.cmd}, 9'h010);
        d = $urandom;
        w = $urandom;
        step(1, 0, 0, d);
        step(1, 1, 0, w[7:0]);
        step(1, 1, 1, w[15:8]);
        step(4, 3, 1, 0);
        chk("flash_buf", m.pbuf[d[6:0]], w);
        step(1, 2, 0, 8'h11);
        step(1, 1, 0, w[15:8]);
        step(4, 3, 1, 0);
        chk("ee_buf", m.ee[d[2:0]], w[15:8]);
        step(1, 2, 0, 8'h04);
        for (int b = 0; b < 4; b++) begin
            step(3, 3, b, 0);
            chk("fuse_rd", rd[15:8], fx[b]);
        end
        step(6, 0, 0, 0);
        chk("exit", {rd[1], hv, trst}, 3'h1);
        wrap_up();
    end
endmodule // parallel_programming_port_tb_top
`default_nettype wire

// ===== verif/ppp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppp_dev_model #(
    parameter int BUSY_NS = 2000
) (
    input wire logic i_load,
    input wire logic [1:0] i_act,
    input wire logic [1:0] i_bs,
    input wire logic i_wr_b,
    input wire logic i_latch,
    input wire logic [7:0] i_bus,
    output logic [7:0] o_drv,
    output logic o_ready_busy_out
);
    logic [7:0] cmd = 8'h00;
    logic [7:0] adr [3];
    logic [7:0] fuse [4] = '{8'h3C, 8'hC0, 8'hF3, 8'h5A};
    logic cmd_bs = 1'b1;
    logic [7:0] dat [2];
    logic [15:0] pbuf [128];
    logic [7:0] ee [8];
    initial o_ready_busy_out = 1'b1;
    always @(posedge i_load) begin
        case (i_act)
            2'h0: if (i_bs != 2'h3) adr[i_bs] = i_bus;
            2'h1: dat[i_bs[0]] = i_bus;
            2'h2: begin
                cmd = i_bus;
                cmd_bs = i_bs[0];
            end
            default: ;
        endcase
    end
    // Write strobes seen while busy are ignored, as a real part would
    always @(negedge i_wr_b) begin
        o_ready_busy_out = 1'b0;
        #(BUSY_NS);
        if (cmd == 8'h80) begin
            fuse[1] = 8'hFF;
            // High fuse bit 3 keeps the EEPROM, 0 when programmed
            if (fuse[3][3]) begin
                for (int i = 0; i < 8; i++) ee[i] = 8'hFF;
            end
        end
        o_ready_busy_out = 1'b1;
    end
    // Word index is the low address byte, seven bits for flash, three for EEPROM
    always @(posedge i_latch) begin
        if (cmd == 8'h10) pbuf[adr[0][6:0]] = {dat[1], dat[0]};
        else if (cmd == 8'h11) ee[adr[0][2:0]] = dat[0];
    end
    // Bench puts this on the bus only while output enable is low
    assign o_drv = (cmd == 8'h04) ? fuse[i_bs] : adr[0];
endmodule // ppp_dev_model
`default_nettype wire
